// file: inc/tcs_defines.svh
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH

`define TCS_CMD_IDLE 4'h0
`define TCS_CMD_CONFIG 4'h1
`define TCS_CMD_RANDID 4'h2
`define TCS_CMD_CRC 4'h3
`define TCS_CMD_TRANSMIT 4'h4
`define TCS_CMD_KEEP 4'h7
`define TCS_CMD_RECEIVE 4'h8
`define TCS_CMD_TRANSCEIVE 4'hC
`define TCS_CMD_AUTOACT 4'hD
`define TCS_CMD_AUTH 4'hE
`define TCS_CMD_SOFTRST 4'hF

`define TCS_ADDR_CMD 8'h01
`define TCS_ADDR_STATUS 8'h04
`define TCS_ADDR_FRAMING 8'h0D
`define TCS_ADDR_MODE 8'h11
`define TCS_ADDR_RXMODE 8'h13
`define TCS_ADDR_CRC_HI 8'h21
`define TCS_ADDR_CRC_LO 8'h22
`define TCS_ADDR_SELFTEST 8'h36

`define TCS_CMD_SLEEP_BIT 4
`define TCS_CMD_RXOFF_BIT 5
`define TCS_STAT_DONE_BIT 0
`define TCS_FRAMING_LAUNCH_BIT 7
`define TCS_RXMODE_MULTI_BIT 2

`define TCS_REG_RST 8'h00
`define TCS_SELFTEST_EN 8'h09
`define TCS_ID1_FIXED 8'h08
`define TCS_CFG_LAST 7'h18
`define TCS_RAND_LAST 7'h09
`define TCS_AUTH_LAST 7'h0B
`define TCS_SELFTEST_LAST 7'h3F

`define TCS_CRC_POLY 16'h1021
`define TCS_CRC_SEED0 16'h0000
`define TCS_CRC_SEED1 16'h5555
`define TCS_CRC_SEED2 16'hAAAA
`define TCS_CRC_SEED3 16'hFFFF
`define TCS_LFSR_SEED 16'hACE1

`define TCS_CLK_PERIOD_NS 10
`define TCS_SPIKE_NS 10
`define TCS_RST_HOLD_NS 100
`define TCS_SPIKE_CYC \
    ((`TCS_SPIKE_NS + `TCS_CLK_PERIOD_NS - 1) / `TCS_CLK_PERIOD_NS)
`define TCS_STARTUP_CYC 1024

`endif

// file: inc/tcs_pkg.sv
`default_nettype none
package tcs_pkg;
    typedef enum logic [3:0] {
        S_IDLE, S_CFG_LOAD, S_CFG_DUMP, S_RAND, S_CRC, S_SELFTEST,
        S_TX, S_RX, S_TRX_WAIT, S_TRX_TX, S_TRX_RX, S_ACT,
        S_AUTH_ARG, S_AUTH, S_SRST
    } tcs_state_t;
endpackage
`default_nettype wire

// file: logic/tcs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcs_defines.svh"

module tcs_sequencer (
    input wire logic MCLK_I,
    input wire logic SRST_I,
    input wire logic RSTPD_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    output logic READY_O,
    input wire logic [7:0] FIFO_RDATA_I,
    input wire logic FIFO_EMPTY_I,
    input wire logic FIFO_FULL_I,
    output logic FIFO_POP_O,
    output logic FIFO_PUSH_O,
    output logic [7:0] FIFO_WDATA_O,
    output logic [7:0] TX_DATA_O,
    output logic TX_VALID_O,
    input wire logic TX_READY_I,
    output logic RX_EN_O,
    input wire logic [7:0] RX_DATA_I,
    input wire logic RX_VALID_I,
    input wire logic RX_END_I,
    output logic RX_OFF_O,
    output logic SLEEP_O,
    output logic ACT_EN_O,
    input wire logic ACT_DONE_I,
    output logic [7:0] ARG_DATA_O,
    output logic ARG_VALID_O,
    output logic AUTH_EN_O,
    input wire logic AUTH_DONE_I
);

    function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            r = r[15] ? ((r << 1) ^ `TCS_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // Maps random byte k onto the ID1 tail, ID2 and ID3 buffer slots.
    function automatic logic [4:0] rand_slot(input logic [6:0] k);
        logic [4:0] s;
        if (k < 7'h03) begin
            s = k[4:0] + 5'h02;
        end else if (k < 7'h09) begin
            s = k[4:0] + 5'h05;
        end else begin
            s = 5'h18;
        end
        return s;
    endfunction

    logic [2:0] pin_sync_q;
    logic [3:0] low_cnt_q;
    logic pin_rst_q;
    logic soft_q;
    logic rst_all;
    logic [10:0] start_cnt_q;
    logic ready_q;
    tcs_pkg::tcs_state_t state_q;
    logic [3:0] cmd_q;
    logic [6:0] idx_q;
    logic [15:0] crc_q;
    logic [15:0] lfsr_q;
    logic pop_q;
    logic push_q;
    logic [7:0] wdata_q;
    logic [7:0] tx_data_q;
    logic tx_valid_q;
    logic rx_en_q;
    logic act_en_q;
    logic auth_en_q;
    logic [7:0] arg_data_q;
    logic arg_valid_q;
    logic done_set_q;
    logic launch_clr_q;
    logic sleep_q;
    logic rxoff_q;
    logic done_q;
    logic [7:0] framing_q;
    logic [7:0] mode_q;
    logic [7:0] rxmode_q;
    logic [7:0] selftest_q;
    logic [7:0] rdata_q;
    logic [7:0] cfg_mem [0:24];
    logic cfg_we;
    logic [4:0] cfg_wa;
    logic [7:0] cfg_wd;
    logic acc_wr;
    logic cmd_wr;
    logic [15:0] crc_in;
    logic [15:0] crc_st;
    logic [15:0] seed;
    logic multi;
    logic tx_state;
    logic rx_state;
    logic tx_end;

    assign rst_all = SRST_I | pin_rst_q | soft_q;
    assign acc_wr = WR_I & ready_q;
    assign cmd_wr = acc_wr & (ADDR_I == `TCS_ADDR_CMD);
    assign multi = rxmode_q[`TCS_RXMODE_MULTI_BIT];
    assign crc_in = crc_upd(crc_q, FIFO_RDATA_I);
    assign crc_st = crc_upd(crc_q, {1'b0, idx_q});
    assign tx_state = (state_q == tcs_pkg::S_TX) ||
                      (state_q == tcs_pkg::S_TRX_TX);
    assign rx_state = (state_q == tcs_pkg::S_RX) ||
                      (state_q == tcs_pkg::S_TRX_RX);
    assign tx_end = !tx_valid_q && !pop_q && FIFO_EMPTY_I;

    always_comb begin
        unique case (mode_q[1:0])
            2'h0: seed = `TCS_CRC_SEED0;
            2'h1: seed = `TCS_CRC_SEED1;
            2'h2: seed = `TCS_CRC_SEED2;
            2'h3: seed = `TCS_CRC_SEED3;
        endcase
    end

    // The reset pin is asynchronous: three stages, then a low must last
    // past the spike window before the device is reset.
    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            pin_sync_q <= 3'h7;
            low_cnt_q <= 4'h0;
            pin_rst_q <= 1'b0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], RSTPD_N_I};
            if (!pin_sync_q[1] && !pin_sync_q[2]) begin
                if (low_cnt_q < 4'(`TCS_SPIKE_CYC)) begin
                    low_cnt_q <= low_cnt_q + 4'h1;
                end
                pin_rst_q <= (low_cnt_q >= 4'(`TCS_SPIKE_CYC));
            end else if (pin_sync_q[1] && pin_sync_q[2]) begin
                low_cnt_q <= 4'h0;
                pin_rst_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (rst_all) begin
            start_cnt_q <= 11'h000;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            start_cnt_q <= start_cnt_q + 11'h001;
            ready_q <= (start_cnt_q == 11'(`TCS_STARTUP_CYC - 1));
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (SRST_I) begin
            lfsr_q <= `TCS_LFSR_SEED;
        end else begin
            lfsr_q <= {lfsr_q[14:0],
                       lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end

    // The buffer has no reset so that all three resets (SRST_I, pin, soft) leave it intact.
    always_comb begin
        cfg_we = 1'b0;
        cfg_wa = idx_q[4:0];
        cfg_wd = FIFO_RDATA_I;
        if (state_q == tcs_pkg::S_CFG_LOAD && !pop_q && !FIFO_EMPTY_I) begin
            cfg_we = 1'b1;
            if (idx_q == 7'h02) begin
                cfg_wd = `TCS_ID1_FIXED;
            end
        end else if (state_q == tcs_pkg::S_RAND) begin
            cfg_we = 1'b1;
            cfg_wa = rand_slot(idx_q);
            cfg_wd = lfsr_q[7:0];
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (cfg_we) begin
            cfg_mem[cfg_wa] <= cfg_wd;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (rst_all) begin
            state_q <= tcs_pkg::S_IDLE;
            cmd_q <= `TCS_CMD_IDLE;
            idx_q <= 7'h00;
            crc_q <= `TCS_CRC_SEED0;
            pop_q <= 1'b0;
            push_q <= 1'b0;
            wdata_q <= 8'h00;
            tx_data_q <= 8'h00;
            tx_valid_q <= 1'b0;
            rx_en_q <= 1'b0;
            act_en_q <= 1'b0;
            auth_en_q <= 1'b0;
            arg_data_q <= 8'h00;
            arg_valid_q <= 1'b0;
            done_set_q <= 1'b0;
            launch_clr_q <= 1'b0;
            soft_q <= 1'b0;
        end else begin
            pop_q <= 1'b0;
            push_q <= 1'b0;
            arg_valid_q <= 1'b0;
            done_set_q <= 1'b0;
            launch_clr_q <= 1'b0;
            if (cmd_wr && WDATA_I[3:0] != `TCS_CMD_KEEP) begin
                // Abort whatever runs; the FIFO is left as it is.
                cmd_q <= WDATA_I[3:0];
                idx_q <= 7'h00;
                tx_valid_q <= 1'b0;
                rx_en_q <= 1'b0;
                act_en_q <= 1'b0;
                auth_en_q <= 1'b0;
                unique case (WDATA_I[3:0])
                    `TCS_CMD_CONFIG: begin
                        state_q <= FIFO_EMPTY_I ? tcs_pkg::S_CFG_DUMP
                                                : tcs_pkg::S_CFG_LOAD;
                    end
                    `TCS_CMD_RANDID: state_q <= tcs_pkg::S_RAND;
                    `TCS_CMD_CRC: begin
                        crc_q <= seed;
                        state_q <= (selftest_q == `TCS_SELFTEST_EN) ?
                                   tcs_pkg::S_SELFTEST : tcs_pkg::S_CRC;
                    end
                    `TCS_CMD_TRANSMIT: state_q <= tcs_pkg::S_TX;
                    `TCS_CMD_RECEIVE: begin
                        state_q <= tcs_pkg::S_RX;
                        rx_en_q <= 1'b1;
                    end
                    `TCS_CMD_TRANSCEIVE: state_q <= tcs_pkg::S_TRX_WAIT;
                    `TCS_CMD_AUTOACT: begin
                        state_q <= tcs_pkg::S_ACT;
                        act_en_q <= 1'b1;
                    end
                    `TCS_CMD_AUTH: state_q <= tcs_pkg::S_AUTH_ARG;
                    `TCS_CMD_SOFTRST: state_q <= tcs_pkg::S_SRST;
                    `TCS_CMD_IDLE: begin
                        state_q <= tcs_pkg::S_IDLE;
                        done_set_q <= 1'b1;
                    end
                    default: state_q <= tcs_pkg::S_IDLE;
                endcase
            end else begin
                unique case (state_q)
                    tcs_pkg::S_IDLE: begin
                    end
                    tcs_pkg::S_CFG_LOAD: begin
                        if (!pop_q && !FIFO_EMPTY_I) begin
                            pop_q <= 1'b1;
                            idx_q <= idx_q + 7'h01;
                            if (idx_q == `TCS_CFG_LAST) begin
                                state_q <= tcs_pkg::S_IDLE;
                                cmd_q <= `TCS_CMD_IDLE;
                                done_set_q <= 1'b1;
                            end
                        end
                    end
                    tcs_pkg::S_CFG_DUMP: begin
                        if (!push_q && !FIFO_FULL_I) begin
                            push_q <= 1'b1;
                            wdata_q <= cfg_mem[idx_q[4:0]];
                            idx_q <= idx_q + 7'h01;
                            if (idx_q == `TCS_CFG_LAST) begin
                                state_q <= tcs_pkg::S_IDLE;
                                cmd_q <= `TCS_CMD_IDLE;
                                done_set_q <= 1'b1;
                            end
                        end
                    end
                    tcs_pkg::S_RAND: begin
                        idx_q <= idx_q + 7'h01;
                        if (idx_q == `TCS_RAND_LAST) begin
                            state_q <= tcs_pkg::S_IDLE;
                            cmd_q <= `TCS_CMD_IDLE;
                            done_set_q <= 1'b1;
                        end
                    end
                    tcs_pkg::S_CRC: begin
                        if (!pop_q && !FIFO_EMPTY_I) begin
                            pop_q <= 1'b1;
                            crc_q <= crc_in;
                        end
                    end
                    tcs_pkg::S_SELFTEST: begin
                        if (!push_q && !FIFO_FULL_I) begin
                            push_q <= 1'b1;
                            wdata_q <= crc_st[7:0];
                            crc_q <= crc_st;
                            idx_q <= idx_q + 7'h01;
                            if (idx_q == `TCS_SELFTEST_LAST) begin
                                state_q <= tcs_pkg::S_IDLE;
                                cmd_q <= `TCS_CMD_IDLE;
                                done_set_q <= 1'b1;
                            end
                        end
                    end
                    tcs_pkg::S_TX, tcs_pkg::S_TRX_TX: begin
                        if (tx_valid_q && TX_READY_I) begin
                            tx_valid_q <= 1'b0;
                        end else if (!tx_valid_q && !pop_q &&
                                     !FIFO_EMPTY_I) begin
                            pop_q <= 1'b1;
                            tx_data_q <= FIFO_RDATA_I;
                            tx_valid_q <= 1'b1;
                        end else if (tx_end) begin
                            if (state_q == tcs_pkg::S_TX) begin
                                state_q <= tcs_pkg::S_IDLE;
                                cmd_q <= `TCS_CMD_IDLE;
                                done_set_q <= 1'b1;
                            end else begin
                                state_q <= tcs_pkg::S_TRX_RX;
                                rx_en_q <= 1'b1;
                            end
                        end
                    end
                    tcs_pkg::S_RX, tcs_pkg::S_TRX_RX: begin
                        if (RX_VALID_I) begin
                            push_q <= 1'b1;
                            wdata_q <= RX_DATA_I;
                        end
                        if (RX_END_I && !multi) begin
                            rx_en_q <= 1'b0;
                            if (state_q == tcs_pkg::S_RX) begin
                                state_q <= tcs_pkg::S_IDLE;
                                cmd_q <= `TCS_CMD_IDLE;
                                done_set_q <= 1'b1;
                            end else begin
                                state_q <= tcs_pkg::S_TRX_WAIT;
                            end
                        end
                    end
                    tcs_pkg::S_TRX_WAIT: begin
                        if (framing_q[`TCS_FRAMING_LAUNCH_BIT]) begin
                            launch_clr_q <= 1'b1;
                            state_q <= tcs_pkg::S_TRX_TX;
                        end
                    end
                    tcs_pkg::S_ACT: begin
                        if (ACT_DONE_I) begin
                            act_en_q <= 1'b0;
                            cmd_q <= `TCS_CMD_TRANSCEIVE;
                            state_q <= tcs_pkg::S_TRX_WAIT;
                        end
                    end
                    tcs_pkg::S_AUTH_ARG: begin
                        if (!pop_q && !FIFO_EMPTY_I) begin
                            pop_q <= 1'b1;
                            arg_data_q <= FIFO_RDATA_I;
                            arg_valid_q <= 1'b1;
                            idx_q <= idx_q + 7'h01;
                            if (idx_q == `TCS_AUTH_LAST) begin
                                auth_en_q <= 1'b1;
                                state_q <= tcs_pkg::S_AUTH;
                            end
                        end
                    end
                    tcs_pkg::S_AUTH: begin
                        if (AUTH_DONE_I) begin
                            auth_en_q <= 1'b0;
                            state_q <= tcs_pkg::S_IDLE;
                            cmd_q <= `TCS_CMD_IDLE;
                            done_set_q <= 1'b1;
                        end
                    end
                    tcs_pkg::S_SRST: soft_q <= 1'b1;
                    default: state_q <= tcs_pkg::S_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (rst_all) begin
            sleep_q <= 1'b0;
            rxoff_q <= 1'b0;
            done_q <= 1'b0;
            framing_q <= `TCS_REG_RST;
            mode_q <= `TCS_REG_RST;
            rxmode_q <= `TCS_REG_RST;
            selftest_q <= `TCS_REG_RST;
        end else begin
            if (cmd_wr) begin
                sleep_q <= WDATA_I[`TCS_CMD_SLEEP_BIT];
                rxoff_q <= WDATA_I[`TCS_CMD_RXOFF_BIT];
            end
            // A finishing command wins over a clearing write.
            if (done_set_q) begin
                done_q <= 1'b1;
            end else if (acc_wr && ADDR_I == `TCS_ADDR_STATUS &&
                         WDATA_I[`TCS_STAT_DONE_BIT]) begin
                done_q <= 1'b0;
            end
            if (acc_wr && ADDR_I == `TCS_ADDR_FRAMING) begin
                framing_q[6:0] <= WDATA_I[6:0];
            end
            if (acc_wr && ADDR_I == `TCS_ADDR_FRAMING &&
                WDATA_I[`TCS_FRAMING_LAUNCH_BIT]) begin
                framing_q[`TCS_FRAMING_LAUNCH_BIT] <= 1'b1;
            end else if (launch_clr_q || (acc_wr &&
                         ADDR_I == `TCS_ADDR_FRAMING)) begin
                framing_q[`TCS_FRAMING_LAUNCH_BIT] <= 1'b0;
            end
            if (acc_wr && ADDR_I == `TCS_ADDR_MODE) begin
                mode_q <= WDATA_I;
            end
            if (acc_wr && ADDR_I == `TCS_ADDR_RXMODE) begin
                rxmode_q <= WDATA_I;
            end
            if (acc_wr && ADDR_I == `TCS_ADDR_SELFTEST) begin
                selftest_q <= WDATA_I;
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (rst_all) begin
            rdata_q <= 8'h00;
        end else if (RD_I && ready_q) begin
            unique case (ADDR_I)
                `TCS_ADDR_CMD: rdata_q <= {2'h0, rxoff_q, sleep_q, cmd_q};
                `TCS_ADDR_STATUS: rdata_q <= {6'h00, ready_q, done_q};
                `TCS_ADDR_FRAMING: rdata_q <= framing_q;
                `TCS_ADDR_MODE: rdata_q <= mode_q;
                `TCS_ADDR_RXMODE: rdata_q <= rxmode_q;
                `TCS_ADDR_CRC_HI: rdata_q <= crc_q[15:8];
                `TCS_ADDR_CRC_LO: rdata_q <= crc_q[7:0];
                `TCS_ADDR_SELFTEST: rdata_q <= selftest_q;
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign RDATA_O = rdata_q;
    assign READY_O = ready_q;
    assign FIFO_POP_O = pop_q;
    assign FIFO_PUSH_O = push_q;
    assign FIFO_WDATA_O = wdata_q;
    assign TX_DATA_O = tx_data_q;
    assign TX_VALID_O = tx_valid_q;
    assign RX_EN_O = rx_en_q;
    assign RX_OFF_O = rxoff_q;
    assign SLEEP_O = sleep_q;
    assign ACT_EN_O = act_en_q;
    assign ARG_DATA_O = arg_data_q;
    assign ARG_VALID_O = arg_valid_q;
    assign AUTH_EN_O = auth_en_q;

endmodule
`default_nettype wire

// file: verification/tcs_fifo_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcs_fifo_model (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic load_i,
    input wire logic [7:0] load_data_i,
    input wire logic pop_i,
    input wire logic push_i,
    input wire logic [7:0] push_data_i,
    output logic [7:0] head_o,
    output logic empty_o,
    output logic full_o,
    output int count_o
);
    logic [7:0] q [$];
    initial {head_o, empty_o, full_o} = 10'h002;
    // Flags are registered so the sequencer never races the queue update.
    always @(posedge clk_i) begin
        if (clr_i) q.delete();
        if (pop_i && q.size() > 0) void'(q.pop_front());
        if (push_i) q.push_back(push_data_i);
        else if (load_i) q.push_back(load_data_i);
        head_o <= q.size() > 0 ? q[0] : ~head_o;
        empty_o <= q.size() == 0;
        full_o <= q.size() >= 64;
        count_o <= q.size();
    end
endmodule
`default_nettype wire

// file: verification/tcs_sequencer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tcs_sequencer_chk (
    input wire logic MCLK_I,
    input wire logic SRST_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic READY_O,
    input wire logic FIFO_EMPTY_I,
    input wire logic FIFO_POP_O,
    input wire logic [7:0] TX_DATA_O,
    input wire logic TX_VALID_O,
    input wire logic TX_READY_I,
    input wire logic RX_EN_O,
    input wire logic SLEEP_O
);
    wire logic cw = WR_I && READY_O && ADDR_I == 8'h01;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (SRST_I);
    property p_rdata; RDATA_O != 8'h00 |-> $past(RD_I); endproperty
    a_rdata: assert property (p_rdata) else $error("rdata unasked");
    property p_pop_gap; FIFO_POP_O |=> !FIFO_POP_O; endproperty
    a_pop_gap: assert property (p_pop_gap) else $error("pop gap");
    property p_pop_empty; FIFO_POP_O |-> !$past(FIFO_EMPTY_I); endproperty
    a_pop_empty: assert property (p_pop_empty) else $error("pop empty");
    property p_rx_on; cw && WDATA_I[3:0] == 4'h8 |-> ##[1:4] RX_EN_O;
    endproperty
    a_rx_on: assert property (p_rx_on) else $error("rx not on");
    property p_sleep; cw && WDATA_I[4] |-> ##[1:4] SLEEP_O; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep lost");
    property p_ready; $fell(SRST_I) |-> !READY_O [*8]; endproperty
    a_ready: assert property (p_ready) else $error("ready early");
    property p_abort; cw && WDATA_I[3:0] == 4'h0
        |-> ##[1:4] !(RX_EN_O || TX_VALID_O); endproperty
    a_abort: assert property (p_abort) else $error("no abort");
    property p_tx_hold; TX_VALID_O && !TX_READY_I && !cw && !$past(cw)
        |=> TX_VALID_O && $stable(TX_DATA_O); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx dropped");
    c_rx: cover property (RX_EN_O);
    c_tx: cover property (TX_VALID_O && TX_READY_I);
    c_pop: cover property (FIFO_POP_O);
endmodule
bind tcs_sequencer tcs_sequencer_chk tcs_sequencer_chk_inst (.MCLK_I, .SRST_I,
    .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .READY_O, .FIFO_EMPTY_I,
    .FIFO_POP_O, .TX_DATA_O, .TX_VALID_O, .TX_READY_I, .RX_EN_O, .SLEEP_O);
`default_nettype wire

// file: verification/tcs_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcs_defines.svh"
module tcs_sequencer_tb_top;
    typedef struct {logic [3:0] c; logic rx; logic dn;} tcs_row_t;
    tcs_row_t rows [9] = '{'{4'h0, 1'b0, 1'b1}, '{4'h8, 1'b1, 1'b0},
        '{4'h7, 1'b1, 1'b0}, '{4'h3, 1'b0, 1'b0}, '{4'h2, 1'b0, 1'b1},
        '{4'h4, 1'b0, 1'b1}, '{4'hC, 1'b0, 1'b0}, '{4'hD, 1'b0, 1'b0},
        '{4'hE, 1'b0, 1'b0}};
    localparam int s_wr = 0, s_rd = 1, s_ld = 2, s_clr = 3, s_rxv = 4;
    logic MCLK_I = 1'b0, SRST_I = 1'b1, TX_READY_I = 1'b0;
    logic [6:0] stb = 7'h00;
    logic [7:0] ADDR_I = 8'h00, WDATA_I = 8'h00, RX_DATA_I = 8'h00, r, h;
    logic [15:0] e;
    wire logic WR_I = stb[0], RD_I = stb[1], RX_VALID_I = stb[4];
    wire logic RX_END_I = stb[5];
    wire logic [7:0] RDATA_O, FIFO_RDATA_I, FIFO_WDATA_O, TX_DATA_O;
    wire logic READY_O, FIFO_EMPTY_I, FIFO_FULL_I, FIFO_POP_O;
    wire logic FIFO_PUSH_O, TX_VALID_O, RX_EN_O;
    int errors = 0, compares = 0, fcnt, n;
    tcs_sequencer tcs_sequencer_inst (.MCLK_I, .SRST_I, .RSTPD_N_I(!stb[6]),
        .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .READY_O, .FIFO_RDATA_I,
        .FIFO_EMPTY_I, .FIFO_FULL_I, .FIFO_POP_O, .FIFO_PUSH_O,
        .FIFO_WDATA_O, .TX_DATA_O, .TX_VALID_O, .TX_READY_I, .RX_EN_O,
        .RX_DATA_I, .RX_VALID_I, .RX_END_I, .RX_OFF_O(), .SLEEP_O(),
        .ACT_EN_O(), .ACT_DONE_I(1'b0), .ARG_DATA_O(), .ARG_VALID_O(),
        .AUTH_EN_O(), .AUTH_DONE_I(1'b0));
    tcs_fifo_model tcs_fifo_model_inst (.clk_i(MCLK_I), .clr_i(stb[3]),
        .load_i(stb[2]), .load_data_i(WDATA_I), .pop_i(FIFO_POP_O),
        .push_i(FIFO_PUSH_O), .push_data_i(FIFO_WDATA_O),
        .head_o(FIFO_RDATA_I), .empty_o(FIFO_EMPTY_I),
        .full_o(FIFO_FULL_I), .count_o(fcnt));
    initial forever #5 MCLK_I = ~MCLK_I;
    task automatic check(input string s, input logic [15:0] v, x);
        compares++;
        if (v !== x) begin
            errors++;
            $display("mismatch %s expected %h seen %h", s, x, v);
        end
    endtask
    task automatic conclude;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One strobe for one cycle: write, read, load, flush, rx, end, pin low.
    task automatic hit(input int k, input logic [7:0] a, d);
        @(posedge MCLK_I);
        ADDR_I <= a;
        WDATA_I <= d;
        stb[k] <= 1'b1;
        @(posedge MCLK_I);
        stb[k] <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        hit(s_rd, a, 8'h00);
        #1 d = RDATA_O;
    endtask
    task automatic wfor(input bit tx, output int i);
        for (i = 0; i < 1200; i++) begin
            if ((tx ? TX_VALID_O : READY_O) === 1'b1) return;
            @(negedge MCLK_I);
        end
        errors++;
        conclude();
    endtask
    initial begin
        repeat (20) @(posedge MCLK_I);
        SRST_I <= 1'b0;
        wfor(1'b0, n);
        check("ready_delay", 16'(n > 1015 && n < 1030), 16'h0001);
        rd(8'h7F, r);
        check("unmapped", {8'h00, r}, 16'h0000);
        foreach (rows[i]) begin
            hit(s_wr, 8'h04, 8'h01);
            hit(s_wr, 8'h01, {3'h0, rows[i].c == 4'h7, rows[i].c});
            repeat (30) @(negedge MCLK_I);
            check("rx_en", {15'h0, RX_EN_O}, {15'h0, rows[i].rx});
            rd(8'h04, r);
            check("done", {15'h0, r[0]}, {15'h0, rows[i].dn});
        end
        for (int s = 0; s < 4; s += 3) begin
            hit(s_wr, 8'h11, 8'(s));
            hit(s_wr, 8'h01, 8'h03);
            repeat (4) @(posedge MCLK_I);
            rd(8'h21, h);
            rd(8'h22, r);
            e = s == 0 ? `TCS_CRC_SEED0 : `TCS_CRC_SEED3;
            check("crc_seed", {h, r}, e);
        end
        hit(s_wr, 8'h01, 8'h00);
        hit(s_ld, 8'h00, 8'h5A);
        hit(s_ld, 8'h00, 8'hC3);
        hit(s_wr, 8'h01, 8'h04);
        for (int k = 0; k < 2; k++) begin
            wfor(1'b1, n);
            repeat (3) @(negedge MCLK_I);
            e = k == 0 ? 16'h005A : 16'h00C3;
            check("tx_data", {8'h00, TX_DATA_O}, e);
            @(posedge MCLK_I);
            TX_READY_I <= 1'b1;
            @(posedge MCLK_I);
            TX_READY_I <= 1'b0;
            @(negedge MCLK_I);
        end
        repeat (10) @(negedge MCLK_I);
        check("tx_left", 16'(fcnt), 16'h0000);
        for (int k = 0; k < 25; k++) hit(s_ld, 8'h00, 8'(k + 16));
        hit(s_wr, 8'h01, 8'h01);
        repeat (150) @(negedge MCLK_I);
        check("cfg_taken", 16'(fcnt), 16'h0000);
        hit(s_wr, 8'h01, 8'h01);
        repeat (150) @(negedge MCLK_I);
        check("cfg_dump", 16'(fcnt), 16'h0019);
        check("cfg_id1", {8'h00, tcs_fifo_model_inst.q[2]}, 16'h0008);
        hit(s_clr, 8'h00, 8'h00);
        hit(s_wr, 8'h01, 8'h08);
        RX_DATA_I <= 8'hA5;
        hit(s_rxv, 8'h00, 8'h00);
        RX_DATA_I <= 8'h5A;
        hit(5, 8'h00, 8'h00);
        repeat (10) @(negedge MCLK_I);
        check("rx_stop", {15'h0, RX_EN_O}, 16'h0000);
        check("rx_byte", {8'h00, FIFO_RDATA_I}, 16'h00A5);
        hit(s_wr, 8'h13, 8'h04);
        hit(s_wr, 8'h01, 8'h08);
        hit(5, 8'h00, 8'h00);
        repeat (10) @(negedge MCLK_I);
        check("rx_multi", {15'h0, RX_EN_O}, 16'h0001);
        hit(s_wr, 8'h01, 8'h0F);
        repeat (5) @(negedge MCLK_I);
        wfor(1'b0, n);
        rd(8'h13, r);
        check("srst_regs", {8'h00, r}, 16'h0000);
        hit(6, 8'h00, 8'h00);
        repeat (8) @(negedge MCLK_I);
        check("spike", {15'h0, READY_O}, 16'h0001);
        @(posedge MCLK_I);
        stb[6] <= 1'b1;
        repeat (12) @(posedge MCLK_I);
        stb[6] <= 1'b0;
        repeat (5) @(negedge MCLK_I);
        check("pin_rst", {15'h0, READY_O}, 16'h0000);
        wfor(1'b0, n);
        hit(s_clr, 8'h00, 8'h00);
        hit(s_wr, 8'h01, 8'h01);
        repeat (150) @(negedge MCLK_I);
        check("cfg_kept", {8'h00, tcs_fifo_model_inst.q[2]}, 16'h0008);
        hit(s_clr, 8'h00, 8'h00);
        hit(s_wr, 8'h36, `TCS_SELFTEST_EN);
        hit(s_wr, 8'h01, 8'h03);
        repeat (150) @(negedge MCLK_I);
        check("selftest", 16'(fcnt), 16'h0040);
        conclude();
    end
endmodule
`default_nettype wire
